// [src/scfg_defines.svh]
// Summary of operation
// R1 - Low-freq select sets clock range
// R2 - Low-freq select from pin or register
// R3 - Override bit chooses pin or register source
// R4 - Power-down after low-freq change
// R5 - Low-freq multiplies line rate by four
// R6 - Legacy mode keeps ratio unmultiplied
// R7 - Mode strap decodes into nine levels
// R8 - Mode levels map to four settings
// R9 - Repeater trees two deep, three wide
// R10 - Repeater forwards traffic, uses aliases
// R11 - Repeater parts need distinct addresses
// R12 - Address strap decodes into ten addresses
// R13 - Register bit chooses address source
// R14 - Lines driven only low, pulled up
// R15 - Start begins a transaction
// R16 - Stop ends a transaction
// R17 - Matching address acknowledged, mismatch not
// R18 - Device acknowledges every written byte
// R19 - Host acks reads, nacks last, stops
// R20 - Transactions open with start, close stop
// R21 - Host tolerates clock stretching
// R22 - Write: address, offset, data; read via restart
// R23 - Straps sampled at power-up, then held
`ifndef SCFG_DEFINES_SVH
`define SCFG_DEFINES_SVH

// ----------------------------------------------------------------
// Device register offsets, fields and reset values
// ----------------------------------------------------------------
`define SCFG_REG_ID 8'h00
`define SCFG_REG_CFG 8'h02
`define SCFG_REG_ALIAS 8'h08
`define SCFG_REG_ALTGT 8'h09
`define SCFG_ID_OVR_BIT 0
`define SCFG_CFG_LEGACY_COMPAT_SELECT_OVR 3
`define SCFG_CFG_LEGACY_COMPAT_SELECT 2
`define SCFG_CFG_LF_OVR 1
`define SCFG_CFG_LF 0
`define SCFG_ID_RST 8'h00
`define SCFG_CFG_RST 4'h0
`define SCFG_ALIAS_RST 7'h00

// ----------------------------------------------------------------
// Strap decoding and line-rate ratio
// ----------------------------------------------------------------
`define SCFG_MODE_LVL_BASE 4'h1
`define SCFG_MODE_LVL_LEGACY 4'h9
`define SCFG_ADDR_LVL1 7'h2C
`define SCFG_ADDR_LVL2 7'h33
`define SCFG_ADDR_LVL_MAX 4'hA
`define SCFG_MULT_NORMAL 3'h1
`define SCFG_MULT_LOWFREQ 3'h4

// ----------------------------------------------------------------
// Host APB register offsets and fields
// ----------------------------------------------------------------
`define SCFG_APB_CMD 12'h000
`define SCFG_APB_STAT 12'h004
`define SCFG_APB_RXD 12'h008
`define SCFG_APB_DIV 12'h00C
`define SCFG_CMD_START 8
`define SCFG_CMD_STOP 9
`define SCFG_CMD_READ 10
`define SCFG_CMD_NACK 11
`define SCFG_DIV_RST 8'h04
`define SCFG_BIT_ACK 4'h8

`endif

// [src/scfg_pkg.sv]
package scfg_pkg;
	// Target-side protocol phases
	typedef enum logic [3:0] {
		DS_IDLE = 4'h0,
		DS_ADDR = 4'h1,
		DS_REG = 4'h2,
		DS_WDATA = 4'h3,
		DS_ACK = 4'h4,
		DS_RDATA = 4'h5,
		DS_RACK = 4'h6
	} scfg_dev_state_e;

	// Controller-side bus phases
	typedef enum logic [3:0] {
		HS_IDLE = 4'h0,
		HS_REL = 4'h1,
		HS_START1 = 4'h2,
		HS_START2 = 4'h3,
		HS_BITLO = 4'h4,
		HS_BITHI = 4'h5,
		HS_STOP1 = 4'h6,
		HS_STOP2 = 4'h7
	} scfg_host_state_e;
endpackage : scfg_pkg

// [src/scfg_if.sv]
`timescale 1ns/1ps
// Two-wire bus with pull-ups: low while any party pulls
interface scfg_if;
	logic scl_dev_o;
	logic scl_dev_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl_host_o;
	logic scl_host_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic scl;
	logic sda;

	// Wired-AND resolution of both ends
	assign scl = !((scl_dev_oe && !scl_dev_o) || (scl_host_oe && !scl_host_o));
	assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));

	modport device (input scl, input sda, output scl_dev_o, output scl_dev_oe, output sda_dev_o, output sda_dev_oe);
	modport host (input scl, input sda, output scl_host_o, output scl_host_oe, output sda_host_o, output sda_host_oe);
endinterface : scfg_if

// [src/scfg_device.sv]
// Added by the designer: the placing of the registers, reached over the serial bus; the APB interface sits in scfg_host, not here.
`timescale 1ns/1ps
`include "scfg_defines.svh"
module scfg_device (
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous reset, active low
	scfg_if.device bus, // Serial control bus
	input wire logic powerdown_input, // Power-down pin, low holds reset
	input wire logic [3:0] mode_strap_level, // Mode strap level 1..9
	input wire logic [3:0] address_strap_input, // Address strap level 1..10
	input wire logic low_freq_pin, // Low-frequency select pin
	output logic low_freq_select, // Effective low-frequency mode
	output logic legacy_compat_select, // Effective legacy mode
	output logic repeater_mode, // Repeater setting from strap
	output logic alt_audio_select, // Alternate audio setting
	output logic long_cable_select, // Long-cable setting
	output logic [2:0] line_rate_mult, // Line-rate ratio multiplier
	output logic [6:0] target_addr, // Effective own address
	output logic fwd_valid, // Pulse: alias hit to forward downstream
	output logic [6:0] fwd_addr, // Downstream address for the alias hit
	output logic fwd_rw // Direction of the forwarded access
);
	// ----------------------------------------------------------------
	// Synchronisers for pins
	// ----------------------------------------------------------------
	logic [12:0] sync1_reg;
	logic [12:0] sync2_reg;
	logic scl_d_reg;
	logic sda_d_reg;
	logic pd_d_reg;
	wire logic scl_s = sync2_reg[0];
	wire logic sda_s = sync2_reg[1];
	wire logic pd_s = sync2_reg[2];
	wire logic lf_pin_s = sync2_reg[3];
	wire logic [3:0] mode_s = sync2_reg[7:4];
	wire logic [3:0] addr_s = sync2_reg[11:8];

	// Two stages before anything reads the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 13'h0003;
			sync2_reg <= 13'h0003;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			pd_d_reg <= 1'b0;
		end else begin
			sync1_reg <= {1'b0, address_strap_input, mode_strap_level, low_freq_pin, powerdown_input, bus.sda, bus.scl};
			sync2_reg <= sync1_reg;
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			pd_d_reg <= pd_s;
		end
	end

	wire logic scl_rise = scl_s && !scl_d_reg;
	wire logic scl_fall = !scl_s && scl_d_reg;
	wire logic start_det = scl_s && scl_d_reg && !sda_s && sda_d_reg; // R15
	wire logic stop_det = scl_s && scl_d_reg && sda_s && !sda_d_reg; // R16

	// ----------------------------------------------------------------
	// Strap capture and decode
	// ----------------------------------------------------------------
	logic [3:0] mode_lvl_reg;
	logic [3:0] addr_lvl_reg;
	logic lf_pin_reg;

	// Straps caught as power-down ends; a later change needs a new power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_lvl_reg <= `SCFG_MODE_LVL_BASE;
			addr_lvl_reg <= `SCFG_MODE_LVL_BASE;
			lf_pin_reg <= 1'b0;
		end else if (pd_s && !pd_d_reg) begin
			mode_lvl_reg <= mode_s; // R23
			addr_lvl_reg <= addr_s; // R23
			lf_pin_reg <= lf_pin_s; // R2 R4
		end
	end

	logic [2:0] mode_code;
	logic strap_legacy;
	logic [6:0] strap_addr;

	// Mode levels 2..8 count in binary, level 9 is legacy only, others fall to level 1
	always_comb begin
		mode_code = 3'h0;
		strap_legacy = 1'b0;
		if (mode_lvl_reg == `SCFG_MODE_LVL_LEGACY) begin
			strap_legacy = 1'b1; // R8
		end else if (mode_lvl_reg > `SCFG_MODE_LVL_BASE && mode_lvl_reg < `SCFG_MODE_LVL_LEGACY) begin
			mode_code = 3'(mode_lvl_reg - `SCFG_MODE_LVL_BASE); // R7 R8
		end
	end

	// Address level 1 is the odd one, levels 2..10 are consecutive
	always_comb begin
		strap_addr = `SCFG_ADDR_LVL1; // R12
		if (addr_lvl_reg > `SCFG_MODE_LVL_BASE && addr_lvl_reg <= `SCFG_ADDR_LVL_MAX) begin
			strap_addr = `SCFG_ADDR_LVL2 + 7'(addr_lvl_reg - 4'h2); // R12
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers and effective settings
	// ----------------------------------------------------------------
	logic [7:0] id_reg;
	logic [3:0] cfg_reg;
	logic [6:0] alias_reg;
	logic [6:0] altgt_reg;

	assign alt_audio_select = mode_code[0]; // R8
	assign repeater_mode = mode_code[1]; // R8
	assign long_cable_select = mode_code[2]; // R8
	assign legacy_compat_select = cfg_reg[`SCFG_CFG_LEGACY_COMPAT_SELECT_OVR] ? cfg_reg[`SCFG_CFG_LEGACY_COMPAT_SELECT] : strap_legacy;
	assign low_freq_select = cfg_reg[`SCFG_CFG_LF_OVR] ? cfg_reg[`SCFG_CFG_LF] : lf_pin_reg; // R2 R3 R1
	// Legacy mode keeps the plain ratio even in low-frequency mode
	assign line_rate_mult = (low_freq_select && !legacy_compat_select) ? `SCFG_MULT_LOWFREQ
		: `SCFG_MULT_NORMAL; // R5 R6
	assign target_addr = id_reg[`SCFG_ID_OVR_BIT] ? id_reg[7:1] : strap_addr; // R13

	// Read view: the ID register shows the address actually in use
	function automatic logic [7:0] reg_read(input logic [7:0] off);
		case (off)
			`SCFG_REG_ID: reg_read = {target_addr, id_reg[`SCFG_ID_OVR_BIT]};
			`SCFG_REG_CFG: reg_read = {4'h0, cfg_reg};
			`SCFG_REG_ALIAS: reg_read = {alias_reg, 1'b0};
			`SCFG_REG_ALTGT: reg_read = {altgt_reg, 1'b0};
			default: reg_read = 8'h00;
		endcase
	endfunction : reg_read

	// ----------------------------------------------------------------
	// Serial target
	// ----------------------------------------------------------------
	scfg_pkg::scfg_dev_state_e st_reg;
	scfg_pkg::scfg_dev_state_e after_ack_reg;
	logic [3:0] cnt_reg;
	logic [7:0] sh_reg;
	logic [7:0] tx_reg;
	logic [7:0] ptr_reg;
	logic acked_reg;
	logic rw_reg;
	logic sda_oe_reg;
	logic host_ack_reg;
	logic wr_en;

	assign bus.scl_dev_o = 1'b0; // R14
	assign bus.scl_dev_oe = 1'b0; // Never stretches
	assign bus.sda_dev_o = 1'b0; // R14
	assign bus.sda_dev_oe = sda_oe_reg;
	wire logic own_hit = sh_reg[7:1] == target_addr;
	wire logic alias_hit = repeater_mode && alias_reg != `SCFG_ALIAS_RST && sh_reg[7:1] == alias_reg;
	assign wr_en = pd_s && st_reg == scfg_pkg::DS_WDATA && scl_fall && cnt_reg == `SCFG_BIT_ACK && !start_det;

	// Byte engine: sample on clock rise, change the data line after clock fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= scfg_pkg::DS_IDLE;
			after_ack_reg <= scfg_pkg::DS_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			tx_reg <= 8'h00;
			ptr_reg <= 8'h00;
			acked_reg <= 1'b0;
			rw_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			host_ack_reg <= 1'b0;
			fwd_valid <= 1'b0;
			fwd_addr <= 7'h00;
			fwd_rw <= 1'b0;
		end else begin
			fwd_valid <= 1'b0;
			if (!pd_s || stop_det) begin
				st_reg <= scfg_pkg::DS_IDLE; // R16 R20
				sda_oe_reg <= 1'b0;
			end else if (start_det) begin
				st_reg <= scfg_pkg::DS_ADDR; // R15 R20
				cnt_reg <= 4'h0;
				sda_oe_reg <= 1'b0;
			end else begin
				case (st_reg)
					scfg_pkg::DS_ADDR, scfg_pkg::DS_REG, scfg_pkg::DS_WDATA: begin
						if (scl_rise) begin
							sh_reg <= {sh_reg[6:0], sda_s};
							cnt_reg <= cnt_reg + 4'h1;
						end else if (scl_fall && cnt_reg == `SCFG_BIT_ACK) begin
							st_reg <= scfg_pkg::DS_ACK;
							if (st_reg == scfg_pkg::DS_ADDR) begin
								acked_reg <= own_hit || alias_hit;
								sda_oe_reg <= own_hit || alias_hit; // R17
								rw_reg <= sh_reg[0];
								fwd_valid <= alias_hit && !own_hit; // R10
								fwd_addr <= altgt_reg; // R10
								fwd_rw <= sh_reg[0];
								after_ack_reg <= sh_reg[0] ? scfg_pkg::DS_RDATA : scfg_pkg::DS_REG; // R22
							end else begin
								acked_reg <= 1'b1;
								sda_oe_reg <= 1'b1; // R18
								after_ack_reg <= scfg_pkg::DS_WDATA; // R22
								ptr_reg <= (st_reg == scfg_pkg::DS_REG) ? sh_reg : ptr_reg + 8'h01;
							end
						end
					end
					scfg_pkg::DS_ACK: begin
						if (scl_fall) begin
							cnt_reg <= 4'h0;
							if (!acked_reg || (rw_reg && alias_hit && !own_hit)) begin
								st_reg <= scfg_pkg::DS_IDLE;
								sda_oe_reg <= 1'b0;
							end else if (after_ack_reg == scfg_pkg::DS_RDATA) begin
								st_reg <= scfg_pkg::DS_RDATA;
								sda_oe_reg <= !reg_read(ptr_reg)[7];
								tx_reg <= {reg_read(ptr_reg)[6:0], 1'b0};
								ptr_reg <= ptr_reg + 8'h01;
							end else begin
								st_reg <= after_ack_reg;
								sda_oe_reg <= 1'b0;
							end
						end
					end
					scfg_pkg::DS_RDATA: begin
						if (scl_rise) begin
							cnt_reg <= cnt_reg + 4'h1;
						end else if (scl_fall) begin
							if (cnt_reg == `SCFG_BIT_ACK) begin
								st_reg <= scfg_pkg::DS_RACK;
								sda_oe_reg <= 1'b0;
							end else begin
								sda_oe_reg <= !tx_reg[7];
								tx_reg <= {tx_reg[6:0], 1'b0};
							end
						end
					end
					scfg_pkg::DS_RACK: begin
						if (scl_rise) begin
							host_ack_reg <= !sda_s; // R19
						end else if (scl_fall) begin
							cnt_reg <= 4'h0;
							if (host_ack_reg) begin
								st_reg <= scfg_pkg::DS_RDATA;
								sda_oe_reg <= !reg_read(ptr_reg)[7];
								tx_reg <= {reg_read(ptr_reg)[6:0], 1'b0};
								ptr_reg <= ptr_reg + 8'h01;
							end else begin
								st_reg <= scfg_pkg::DS_IDLE; // R19
							end
						end
					end
					default: begin
						sda_oe_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	// Writes land as the ack slot opens; power-down clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			id_reg <= `SCFG_ID_RST;
			cfg_reg <= `SCFG_CFG_RST;
			alias_reg <= `SCFG_ALIAS_RST;
			altgt_reg <= `SCFG_ALIAS_RST;
		end else if (!pd_s) begin
			id_reg <= `SCFG_ID_RST;
			cfg_reg <= `SCFG_CFG_RST;
			alias_reg <= `SCFG_ALIAS_RST;
			altgt_reg <= `SCFG_ALIAS_RST;
		end else if (wr_en) begin
			case (ptr_reg)
				`SCFG_REG_ID: id_reg <= sh_reg; // R13
				`SCFG_REG_CFG: cfg_reg <= sh_reg[3:0]; // R3
				`SCFG_REG_ALIAS: alias_reg <= sh_reg[7:1]; // R10
				`SCFG_REG_ALTGT: altgt_reg <= sh_reg[7:1];
				default: ;
			endcase
		end
	end
endmodule : scfg_device

// [src/scfg_host.sv]
`timescale 1ns/1ps
`include "scfg_defines.svh"
module scfg_host (
	input wire logic pclk, // System clock
	input wire logic presetn, // Asynchronous reset, active low
	scfg_if.host bus, // Serial control bus
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr // APB error on unmapped address
);
	// ----------------------------------------------------------------
	// Bus line synchronisers
	// ----------------------------------------------------------------
	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 2'h3;
			sync2_reg <= 2'h3;
		end else begin
			sync1_reg <= {bus.sda, bus.scl};
			sync2_reg <= sync1_reg;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	scfg_pkg::scfg_host_state_e st_reg;
	logic [11:0] cmd_reg;
	logic [7:0] div_reg;
	logic [7:0] rx_reg;
	logic nack_reg;
	logic busy;
	wire logic acc = psel && penable;
	wire logic mapped = paddr == `SCFG_APB_CMD || paddr == `SCFG_APB_STAT || paddr == `SCFG_APB_RXD
		|| paddr == `SCFG_APB_DIV;
	wire logic go = acc && pwrite && paddr == `SCFG_APB_CMD && !busy;

	assign busy = st_reg != scfg_pkg::HS_IDLE;
	assign pready = 1'b1; // No wait states
	assign pslverr = acc && !mapped;

	// Read data taken in setup, stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			case (paddr)
				`SCFG_APB_CMD: prdata <= {20'h00000, cmd_reg};
				`SCFG_APB_STAT: prdata <= {30'h00000000, nack_reg, busy};
				`SCFG_APB_RXD: prdata <= {24'h000000, rx_reg};
				`SCFG_APB_DIV: prdata <= {24'h000000, div_reg};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// Commands while busy are dropped; poll busy first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= 12'h000;
			div_reg <= `SCFG_DIV_RST;
		end else begin
			if (go) begin
				cmd_reg <= pwdata[11:0];
			end
			if (acc && pwrite && paddr == `SCFG_APB_DIV) begin
				div_reg <= pwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus engine: one byte per command, optional start before and stop after
	// ----------------------------------------------------------------
	logic [7:0] tmr_reg;
	logic [3:0] bit_reg;
	logic [7:0] tx_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;
	wire logic tdone = tmr_reg == 8'h00;
	wire logic rd = cmd_reg[`SCFG_CMD_READ];

	assign bus.scl_host_o = 1'b0; // R14
	assign bus.scl_host_oe = scl_oe_reg;
	assign bus.sda_host_o = 1'b0; // R14
	assign bus.sda_host_oe = sda_oe_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= scfg_pkg::HS_IDLE;
			tmr_reg <= 8'h00;
			bit_reg <= 4'h0;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			nack_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else begin
			if (!tdone) begin
				tmr_reg <= tmr_reg - 8'h01;
			end
			case (st_reg)
				scfg_pkg::HS_IDLE: begin
					if (go) begin
						tx_reg <= pwdata[7:0];
						bit_reg <= 4'h0;
						tmr_reg <= div_reg;
						st_reg <= pwdata[`SCFG_CMD_START] ? scfg_pkg::HS_REL : scfg_pkg::HS_BITLO; // R20
					end
				end
				scfg_pkg::HS_REL: begin
					// Repeated start: free data, then clock, before pulling data low
					sda_oe_reg <= 1'b0;
					if (!sda_oe_reg) begin
						scl_oe_reg <= 1'b0;
					end
					if (!tdone || !sync2_reg[0]) begin
						tmr_reg <= tdone ? div_reg : tmr_reg - 8'h01; // R21
					end else begin
						tmr_reg <= div_reg;
						st_reg <= scfg_pkg::HS_START1;
					end
				end
				scfg_pkg::HS_START1: begin
					sda_oe_reg <= 1'b1; // R15
					if (tdone) begin
						tmr_reg <= div_reg;
						st_reg <= scfg_pkg::HS_START2;
					end
				end
				scfg_pkg::HS_START2: begin
					if (tdone) begin
						scl_oe_reg <= 1'b1;
						tmr_reg <= div_reg;
						st_reg <= scfg_pkg::HS_BITLO;
					end
				end
				scfg_pkg::HS_BITLO: begin
					// Data moves a cycle after the clock falls
					if (bit_reg == `SCFG_BIT_ACK) begin
						sda_oe_reg <= rd && !cmd_reg[`SCFG_CMD_NACK]; // R19
					end else begin
						sda_oe_reg <= !rd && !tx_reg[7];
					end
					if (tdone) begin
						scl_oe_reg <= 1'b0;
						tmr_reg <= div_reg;
						st_reg <= scfg_pkg::HS_BITHI;
					end
				end
				scfg_pkg::HS_BITHI: begin
					// High phase counts once the line is high
					if (!sync2_reg[0]) begin
						tmr_reg <= div_reg; // R21
					end else if (tdone) begin
						scl_oe_reg <= 1'b1;
						tmr_reg <= div_reg;
						bit_reg <= bit_reg + 4'h1;
						tx_reg <= {tx_reg[6:0], 1'b0};
						if (bit_reg == `SCFG_BIT_ACK) begin
							nack_reg <= sync2_reg[1]; // R17
							st_reg <= cmd_reg[`SCFG_CMD_STOP] ? scfg_pkg::HS_STOP1 : scfg_pkg::HS_IDLE;
						end else begin
							rx_reg <= {rx_reg[6:0], sync2_reg[1]};
							st_reg <= scfg_pkg::HS_BITLO;
						end
					end
				end
				scfg_pkg::HS_STOP1: begin
					sda_oe_reg <= 1'b1;
					if (tdone) begin
						scl_oe_reg <= 1'b0;
						tmr_reg <= div_reg;
						st_reg <= scfg_pkg::HS_STOP2;
					end
				end
				scfg_pkg::HS_STOP2: begin
					if (!sync2_reg[0]) begin
						tmr_reg <= div_reg; // R21
					end else if (tdone) begin
						sda_oe_reg <= 1'b0; // R16 R20
						st_reg <= scfg_pkg::HS_IDLE;
					end
				end
				default: begin
					st_reg <= scfg_pkg::HS_IDLE;
				end
			endcase
		end
	end
endmodule : scfg_host

// [verif/scfg_properties.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Wire-level checks on the two-wire bus
// ----------------------------------------
module scfg_properties (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, low
	input wire logic scl, // Bus clock
	input wire logic sda, // Bus data
	input wire logic scl_dev_o, // Dev scl
	input wire logic scl_dev_oe, // Dev scl pull
	input wire logic sda_dev_o, // Dev sda
	input wire logic sda_dev_oe, // Dev sda pull
	input wire logic scl_host_o, // Host scl
	input wire logic scl_host_oe, // Host scl pull
	input wire logic sda_host_o, // Host sda
	input wire logic sda_host_oe // Host sda pull
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// A driven line must be low, the pull-ups make the high level
	property p_dev_sda_low; sda_dev_oe |-> !sda_dev_o; endproperty
	a_dev_sda_low: assert property (p_dev_sda_low) else $error("device drives data high");
	property p_host_sda_low; sda_host_oe |-> !sda_host_o; endproperty
	a_host_sda_low: assert property (p_host_sda_low) else $error("host drives data high");
	property p_host_scl_low; scl_host_oe |-> !scl_host_o; endproperty
	a_host_scl_low: assert property (p_host_scl_low) else $error("host drives clock high");
	// The target never stretches, so it never touches the clock
	property p_dev_no_stretch; !scl_dev_oe; endproperty
	a_dev_no_stretch: assert property (p_dev_no_stretch) else $error("device pulls clock");
	// Device data moves only in the low phase, or it would fake a start or stop
	property p_dev_sda_steady; $changed(sda_dev_oe) |-> !scl && !$past(scl); endproperty
	a_dev_sda_steady: assert property (p_dev_sda_steady) else $error("device data moved in high phase");
	// An acknowledge stands for three cycles after the clock rises
	property p_dev_hold; $rose(scl) && sda_dev_oe |=> sda_dev_oe [*3]; endproperty
	a_dev_hold: assert property (p_dev_hold) else $error("device ack dropped early");
	// A start is followed by the first clock low within a bounded time
	property p_host_start; $rose(sda_host_oe) && scl && $past(scl) |-> ##[1:40] !scl; endproperty
	a_host_start: assert property (p_host_start) else $error("no clock after start");
	// After a stop both lines stay released for two cycles
	property p_host_stop; $fell(sda_host_oe) && scl && $past(scl) |=> (scl && sda) [*2]; endproperty
	a_host_stop: assert property (p_host_stop) else $error("bus not idle after stop");

	// Main scenarios
	c_start: cover property ($fell(sda) && scl && $past(scl));
	c_ack: cover property ($rose(scl) && sda_dev_oe);
	c_stop: cover property ($rose(sda) && scl && $past(scl));
endmodule : scfg_properties

// [verif/tb_top.sv]
`timescale 1ns/1ps
`include "scfg_defines.svh"
// ----------------------------------------
// Both ends joined, host driven over APB
// ----------------------------------------
module tb_top;
	typedef struct packed {logic [3:0] mode; logic [3:0] adr; logic pin; logic [3:0] cfg; logic lf;
		logic [2:0] mult; logic [6:0] addr;} scfg_row_s;
	logic pclk, presetn, powerdown_input, low_freq_pin, psel, penable, pwrite, pready, pslverr, fwd_valid, fwd_rw;
	logic legacy_compat_select, repeater_mode, alt_audio_select, long_cable_select, low_freq_select;
	logic [3:0] mode_strap_level, address_strap_input;
	logic [2:0] line_rate_mult;
	logic [6:0] target_addr, fwd_addr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] fwd_seen;
	logic e;
	int err_total, checked, fwd_cnt, i;
	wire logic [14:0] cfg_seen = {legacy_compat_select, long_cable_select, repeater_mode, alt_audio_select,
		low_freq_select, line_rate_mult, target_addr};
	// Mode levels 0 and 10 fall back to level 1
	scfg_row_s rows [11] = '{'{4'h0,4'h0,1'h1,4'h0,1'h1,3'h4,7'h2C}, '{4'h1,4'h1,1'h0,4'h0,1'h0,3'h1,7'h2C},
		'{4'h2,4'h2,1'h1,4'h1,1'h1,3'h4,7'h33}, '{4'h3,4'h3,1'h0,4'h2,1'h0,3'h1,7'h34},
		'{4'h4,4'h4,1'h0,4'h3,1'h0,3'h1,7'h35}, '{4'h5,4'h5,1'h1,4'h4,1'h1,3'h4,7'h36},
		'{4'h6,4'h6,1'h0,4'h5,1'h0,3'h1,7'h37}, '{4'h7,4'h7,1'h0,4'h6,1'h0,3'h1,7'h38},
		'{4'h8,4'h8,1'h0,4'h7,1'h0,3'h1,7'h39}, '{4'h9,4'h9,1'h1,4'h8,1'h1,3'h1,7'h3A},
		'{4'hA,4'hA,1'h0,4'h0,1'h0,3'h1,7'h3B}};

	scfg_if u_scfg_if ();
	scfg_device u_scfg_device (.pclk, .presetn, .bus(u_scfg_if.device), .powerdown_input, .mode_strap_level,
		.address_strap_input, .low_freq_pin, .low_freq_select, .legacy_compat_select, .repeater_mode,
		.alt_audio_select, .long_cable_select, .line_rate_mult, .target_addr, .fwd_valid, .fwd_addr, .fwd_rw);
	scfg_host u_scfg_host (.pclk, .presetn, .bus(u_scfg_if.host), .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);
	scfg_properties u_scfg_properties (.pclk, .presetn, .scl(u_scfg_if.scl), .sda(u_scfg_if.sda),
		.scl_dev_o(u_scfg_if.scl_dev_o), .scl_dev_oe(u_scfg_if.scl_dev_oe), .sda_dev_o(u_scfg_if.sda_dev_o),
		.sda_dev_oe(u_scfg_if.sda_dev_oe), .scl_host_o(u_scfg_if.scl_host_o), .scl_host_oe(u_scfg_if.scl_host_oe),
		.sda_host_o(u_scfg_if.sda_host_o), .sda_host_oe(u_scfg_if.sda_host_oe));

	// 25 MHz clock
	always #20 pclk = ~pclk;

	// Forward pulses last one cycle: count and latch each
	always @(posedge pclk) begin
		if (fwd_valid === 1'h1) begin
			fwd_cnt++;
			fwd_seen = {fwd_rw, fwd_addr};
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic close_out();
		if (err_total == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out

	// One APB transfer; an idle edge first so psel is never assigned twice
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'h1 && ++n < 50);
		if (n >= 50) chk("pready", 32'h0, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	// One byte on the bus, then poll busy and compare the acknowledge bit
	task automatic xb(input logic [11:0] c, input logic nack_exp);
		int n;
		apb(1'h1, `SCFG_APB_CMD, {20'h0, c}, q, e);
		for (n = 0; n < 500; n++) begin
			apb(1'h0, `SCFG_APB_STAT, 32'h0, q, e);
			if (q[0] === 1'h0) break;
		end
		if (n == 500) chk("busy", 32'h1, 32'h0);
		chk("ack", {31'h0, q[1]}, {31'h0, nack_exp});
	endtask : xb

	// Power-down pulse; straps are taken as it ends
	task automatic pd();
		@(posedge pclk);
		powerdown_input <= 1'h0;
		repeat (5) @(posedge pclk);
		powerdown_input <= 1'h1;
		repeat (8) @(posedge pclk);
	endtask : pd

	// Watchdog, far beyond the run
	initial begin
		#800000;
		err_total++;
		close_out();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{pclk, presetn, powerdown_input, low_freq_pin, psel, penable, pwrite} = 7'h0;
		{mode_strap_level, address_strap_input, paddr, pwdata} = 52'h0;
		{err_total, checked, fwd_cnt} = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		for (i = 0; i < 11; i++) begin
			mode_strap_level <= rows[i].mode;
			address_strap_input <= rows[i].adr;
			low_freq_pin <= rows[i].pin;
			pd();
			chk("cfg", 32'(cfg_seen), 32'({rows[i].cfg, rows[i].lf, rows[i].mult, rows[i].addr}));
		end
		// Straps moved without power-down change nothing
		mode_strap_level <= 4'h3;
		address_strap_input <= 4'h1;
		low_freq_pin <= 1'h1;
		repeat (10) @(posedge pclk);
		chk("held", 32'(cfg_seen), 32'h000000BB);
		address_strap_input <= 4'hA;
		low_freq_pin <= 1'h0;
		pd();
		chk("repeater", 32'(repeater_mode), 32'h1);
		// Register write switches low frequency on through the override
		xb(12'h176, 1'h0);
		xb(12'h002, 1'h0);
		xb(12'h20F, 1'h0);
		chk("lf_mult", {28'h0, low_freq_select, line_rate_mult}, 32'h00000009);
		// Read back via repeated start, NACK last
		xb(12'h176, 1'h0);
		xb(12'h002, 1'h0);
		xb(12'h177, 1'h0);
		xb(12'hE00, 1'h1);
		apb(1'h0, `SCFG_APB_RXD, 32'h0, q, e);
		chk("rxd", {24'h0, q[7:0]}, 32'h0000000F);
		// Alias 0x50 onto downstream 0x20
		xb(12'h176, 1'h0);
		xb(12'h008, 1'h0);
		xb(12'h0A0, 1'h0);
		xb(12'h240, 1'h0);
		xb(12'h1A0, 1'h0);
		xb(12'h201, 1'h0);
		chk("fwd", {fwd_cnt[23:0], fwd_seen}, 32'h00000120);
		// Own address 0x28 by register, old one refused
		xb(12'h176, 1'h0);
		xb(12'h000, 1'h0);
		xb(12'h251, 1'h0);
		chk("addr_ovr", 32'(target_addr), 32'h28);
		xb(12'h376, 1'h1);
		xb(12'h150, 1'h0);
		xb(12'h200, 1'h0);
		// Host register map: divider reset value, unmapped word
		apb(1'h0, `SCFG_APB_DIV, 32'h0, q, e);
		chk("div", q, 32'h00000004);
		apb(1'h0, 12'h010, 32'h0, q, e);
		chk("unmapped", {q[30:0], e}, 32'h00000001);
		// Mid-run reset releases lines, restores level 1
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk("reset", {u_scfg_if.sda_dev_oe, u_scfg_if.sda_host_oe, u_scfg_if.scl_host_oe, 7'h0, target_addr, line_rate_mult},
			32'h00000161);
		presetn <= 1'h1;
		repeat (2) @(posedge pclk);
		close_out();
	end
endmodule : tb_top
